// ---- hdl/cfp_cpu_regs.sv ----
`timescale 1ns/1ns
// ==========================================================
// Behaviour
// RULE_01: Upper and lower index form 16-bit pointer
// RULE_02: Reset clears upper index, keeps lower
// RULE_03: Lower index works as 8-bit data register
// RULE_04: 16-bit stack pointer to next free slot
// RULE_05: Stack adjust adds sign-extended byte
// RULE_06: Reset loads stack pointer with 0x00FF
// RULE_07: Stack low reset touches low byte only
// RULE_08: Program counter advances on every fetch
// RULE_09: Flow changes load a non-sequential target
// RULE_10: Reset loads counter from top vector
// RULE_11: Flag bits 6 and 5 read one
// RULE_12: Overflow flag tracks signed overflow
// RULE_13: Half carry from bit 3 on adds
// RULE_14: Decimal adjust corrects BCD using flags
// RULE_15: Mask bit blocks maskable interrupts
// RULE_16: Interrupt entry sets mask after stacking
// RULE_17: No interrupt right after mask clear
// RULE_18: Negative flag copies result top bit
// RULE_19: Zero flag marks all-zero result
// RULE_20: Carry flag on carry or borrow
// RULE_21: Accumulator feeds arithmetic, kept over reset
// RULE_22: CPU registers are not memory mapped
// RULE_23: Flag writes ignore bits 6 and 5
module cfp_cpu_regs (
   input  wire logic                 mclk,
   input  wire logic                 rst_n,
   input  wire cfp_pkg::cfp_cmd_type cmd,
   input  wire logic                 irqPending,
   input  wire logic [7:0]           memRdata,
   output logic                      cmdReady,
   output logic                      memRead,
   output logic [15:0]               memAddr,
   output logic [15:0]               index,
   output logic [15:0]               stackPointer,
   output logic [15:0]               programCounter,
   output logic [7:0]                conditionFlags,
   output logic [7:0]                accumulator,
   output logic                      irqTake,
   input  wire logic                 awvalid,
   input  wire logic [7:0]           awaddr,
   input  wire logic                 wvalid,
   input  wire logic [31:0]          wdata,
   input  wire logic [3:0]           wstrb,
   input  wire logic                 bready,
   input  wire logic                 arvalid,
   input  wire logic [7:0]           araddr,
   input  wire logic                 rready,
   output logic                      awready,
   output logic                      wready,
   output logic                      bvalid,
   output logic [1:0]                bresp,
   output logic                      arready,
   output logic                      rvalid,
   output logic [31:0]               rdata,
   output logic [1:0]                rresp
);
   import cfp_pkg::*;

   cfp_state_type state;
   cfp_state_type next_state;
   logic [7:0]    hReg;
   logic [7:0]    xReg;
   logic [7:0]    next_h;
   logic [7:0]    next_x;
   logic [7:0]    next_acc;
   logic [15:0]   next_sp;
   logic [15:0]   next_pc;
   logic [7:0]    next_flags;
   logic          next_memRead;
   logic [15:0]   next_memAddr;
   logic          next_ready;
   logic          next_irqTake;
   logic          inhibit;
   logic          next_inhibit;
   logic          freeze;
   logic          next_freeze;
   logic          take;
   logic          branchOk;
   logic          signedLess;
   logic          clearsMask;
   logic [15:0]   sext8;
   logic [4:0]    nibSum;
   logic [7:0]    aluA;
   logic [7:0]    aluB;
   logic [7:0]    aluRes;
   logic [7:0]    aluFlags;

   function automatic logic on_x(input cfp_op_type op);
      on_x = op inside {OP_LDX, OP_TAX, OP_XCLR, OP_XINC, OP_XDEC, OP_XCOM,
                        OP_XNEG, OP_XLSL, OP_XLSR, OP_XROL, OP_XROR};
   endfunction

   function automatic logic [7:0] flags16(input logic [7:0] f,
                                          input logic [15:0] val);
      flags16 = f;
      flags16[CFP_V_BIT] = 1'b0;
      flags16[CFP_N_BIT] = val[15]; // RULE_18
      flags16[CFP_Z_BIT] = (val == 16'h0000); // RULE_19
   endfunction

   // ==========================================================
   // Command decode
   assign take = cmd.valid && cmdReady;
   assign index = {hReg, xReg}; // RULE_01
   assign sext8 = {{8{cmd.data[7]}}, cmd.data[7:0]};
   assign nibSum = {1'b0, accumulator[3:0]} + {1'b0, cmd.data[3:0]};
   assign aluA = on_x(cmd.op) && cmd.op != OP_TAX ? xReg : accumulator; // RULE_21
   assign aluB = cmd.op == OP_TAX ? accumulator : cmd.op == OP_TXA ? xReg : cmd.data[7:0];
   assign signedLess = conditionFlags[CFP_N_BIT] ^ conditionFlags[CFP_V_BIT];
   assign clearsMask = take && conditionFlags[CFP_I_BIT]
                       && (cmd.op == OP_MCLR
                           || (cmd.op == OP_TAP && !accumulator[CFP_I_BIT]));

   always_comb begin
      case (cmd.op)
         OP_BRA: branchOk = 1'b1;
         OP_SGT: branchOk = !(conditionFlags[CFP_Z_BIT] || signedLess); // RULE_12
         OP_SGE: branchOk = !signedLess;
         OP_SLE: branchOk = conditionFlags[CFP_Z_BIT] || signedLess;
         OP_SLT: branchOk = signedLess;
         default: branchOk = 1'b0;
      endcase
   end

   cfp_alu alu (
      .op       (cmd.op),
      .opA      (aluA),
      .opB      (aluB),
      .flagsIn  (conditionFlags),
      .result   (aluRes),
      .flagsOut (aluFlags)
   );

   // ==========================================================
   // Pointer, counter and flag registers
   always_comb begin
      next_state = state;
      next_h = hReg;
      next_sp = stackPointer;
      next_pc = programCounter;
      next_flags = conditionFlags;
      next_memRead = memRead;
      next_memAddr = memAddr;
      next_ready = cmdReady;
      next_irqTake = 1'b0;
      next_inhibit = inhibit;
      case (state)
         CFP_ST_VECHI: begin
            next_state = CFP_ST_VECLO;
            next_memAddr = CFP_VEC_LO_ADDR;
         end
         CFP_ST_VECLO: begin
            next_state = CFP_ST_VECDONE;
            next_memRead = 1'b0;
            next_pc[15:8] = memRdata; // RULE_10
         end
         CFP_ST_VECDONE: begin
            next_state = CFP_ST_RUN;
            next_pc[7:0] = memRdata; // RULE_10
            next_ready = !freeze;
         end
         CFP_ST_RUN: begin
            // Freeze only holds off new commands; one may still land
            next_ready = !freeze;
            if (take) begin
               case (cmd.op)
                  OP_FETCH: next_pc = programCounter + 16'h0001; // RULE_08
                  OP_JUMP: next_pc = cmd.data; // RULE_09
                  OP_INTENTRY: begin
                     next_pc = cmd.data; // RULE_09
                     next_flags[CFP_I_BIT] = 1'b1; // RULE_16
                  end
                  OP_BRA, OP_SGT, OP_SGE, OP_SLE, OP_SLT: begin
                     if (branchOk) next_pc = programCounter + sext8; // RULE_09
                  end
                  OP_LDHX: begin
                     next_h = cmd.data[15:8]; // RULE_01
                     next_flags = flags16(conditionFlags, cmd.data);
                  end
                  OP_STORE16: next_flags = flags16(conditionFlags, cmd.data);
                  OP_STKADJ: next_sp = stackPointer + sext8; // RULE_05
                  OP_STKLO: next_sp[7:0] = CFP_STK_LO_RESET; // RULE_07
                  OP_SPINC: next_sp = stackPointer + 16'h0001; // RULE_04
                  OP_SPDEC: next_sp = stackPointer - 16'h0001; // RULE_04
                  OP_LDSP: next_sp = cmd.data; // RULE_04
                  OP_TAP: next_flags = accumulator | CFP_FIXED_ONES; // RULE_23
                  OP_MCLR: next_flags[CFP_I_BIT] = 1'b0;
                  OP_SEI: next_flags[CFP_I_BIT] = 1'b1;
                  default: next_flags = aluFlags;
               endcase
               // Decision uses the mask as it stood before this command
               if (cmd.boundary) begin
                  next_irqTake = irqPending && !conditionFlags[CFP_I_BIT] // RULE_15
                                 && !inhibit && !clearsMask; // RULE_17
                  next_inhibit = 1'b0;
               end else if (clearsMask) begin
                  next_inhibit = 1'b1; // RULE_17
               end
            end
         end
         default: next_state = CFP_ST_VECHI;
      endcase
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         state <= CFP_ST_VECHI;
         hReg <= CFP_H_RESET; // RULE_02
         stackPointer <= CFP_STK_RESET; // RULE_06
         programCounter <= 16'h0000;
         conditionFlags <= CFP_FLAGS_RESET; // RULE_11
         memRead <= 1'b1;
         memAddr <= CFP_VEC_HI_ADDR;
         cmdReady <= 1'b0;
         irqTake <= 1'b0;
         inhibit <= 1'b0;
      end else begin
         state <= next_state;
         hReg <= next_h;
         stackPointer <= next_sp;
         programCounter <= next_pc;
         conditionFlags <= next_flags;
         memRead <= next_memRead;
         memAddr <= next_memAddr;
         cmdReady <= next_ready;
         irqTake <= next_irqTake;
         inhibit <= next_inhibit;
      end
   end

   // ==========================================================
   // Data registers; reset leaves them alone on purpose
   always_comb begin
      next_x = xReg;
      next_acc = accumulator;
      if (take) begin
         if (on_x(cmd.op)) next_x = aluRes; // RULE_03
         else if (cmd.op == OP_LDHX) next_x = cmd.data[7:0];
         else if (cmd.op == OP_TPA) next_acc = conditionFlags;
         else if (cmd.op inside {OP_LDA, OP_TXA, OP_ADD, OP_ADC, OP_SUB,
                                 OP_SBC, OP_DADJ}) next_acc = aluRes; // RULE_21
      end
   end

   always_ff @(posedge mclk) begin
      xReg <= next_x; // RULE_02
      accumulator <= next_acc; // RULE_21
   end

   // ==========================================================
   // Register bus slave: observation and freeze control only
   logic        awHeld;
   logic        wHeld;
   logic [7:0]  awAddr;
   logic        wBit;
   logic        wLane;
   logic        next_awHeld;
   logic        next_wHeld;
   logic [7:0]  next_awAddr;
   logic        next_wBit;
   logic        next_wLane;
   logic        next_awready;
   logic        next_wready;
   logic        next_bvalid;
   logic [1:0]  next_bresp;
   logic        next_arready;
   logic        next_rvalid;
   logic [31:0] next_rdata;
   logic [1:0]  next_rresp;

   always_comb begin
      next_awHeld = awHeld;
      next_wHeld = wHeld;
      next_awAddr = awAddr;
      next_wBit = wBit;
      next_wLane = wLane;
      next_bvalid = bvalid;
      next_bresp = bresp;
      next_freeze = freeze;
      next_rvalid = rvalid;
      next_rdata = rdata;
      next_rresp = rresp;
      if (awvalid && awready) begin
         next_awHeld = 1'b1;
         next_awAddr = awaddr;
      end
      if (wvalid && wready) begin
         next_wHeld = 1'b1;
         next_wBit = wdata[CFP_FREEZE_BIT];
         next_wLane = wstrb[0];
      end
      if (bvalid && bready) next_bvalid = 1'b0;
      if (awHeld && wHeld && !bvalid) begin
         next_bvalid = 1'b1;
         next_awHeld = 1'b0;
         next_wHeld = 1'b0;
         // CPU registers themselves cannot be written from the bus
         if (awAddr == CFP_ADDR_CTRL) begin
            next_bresp = CFP_RESP_OKAY;
            if (wLane) next_freeze = wBit;
         end else begin
            next_bresp = CFP_RESP_SLVERR; // RULE_22
         end
      end
      if (rvalid && rready) next_rvalid = 1'b0;
      if (arvalid && arready) begin
         next_rvalid = 1'b1;
         next_rresp = CFP_RESP_OKAY;
         case (araddr)
            CFP_ADDR_INDEX: next_rdata = {16'h0000, index};
            CFP_ADDR_STACK: next_rdata = {16'h0000, stackPointer};
            CFP_ADDR_CNT: next_rdata = {16'h0000, programCounter};
            CFP_ADDR_ACCFLG: next_rdata = {16'h0000, accumulator, conditionFlags};
            CFP_ADDR_CTRL: begin
               next_rdata = 32'h0000_0000;
               next_rdata[CFP_FREEZE_BIT] = freeze;
               next_rdata[CFP_RUN_BIT] = (state == CFP_ST_RUN);
               next_rdata[CFP_INHIBIT_BIT] = inhibit;
            end
            default: begin
               next_rdata = 32'h0000_0000;
               next_rresp = CFP_RESP_SLVERR;
            end
         endcase
      end
      next_awready = !next_awHeld && !next_bvalid;
      next_wready = !next_wHeld && !next_bvalid;
      next_arready = !next_rvalid;
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         awHeld <= 1'b0;
         wHeld <= 1'b0;
         awAddr <= 8'h00;
         wBit <= 1'b0;
         wLane <= 1'b0;
         awready <= 1'b1;
         wready <= 1'b1;
         bvalid <= 1'b0;
         bresp <= CFP_RESP_OKAY;
         freeze <= 1'b0;
         arready <= 1'b1;
         rvalid <= 1'b0;
         rdata <= 32'h0000_0000;
         rresp <= CFP_RESP_OKAY;
      end else begin
         awHeld <= next_awHeld;
         wHeld <= next_wHeld;
         awAddr <= next_awAddr;
         wBit <= next_wBit;
         wLane <= next_wLane;
         awready <= next_awready;
         wready <= next_wready;
         bvalid <= next_bvalid;
         bresp <= next_bresp;
         freeze <= next_freeze;
         arready <= next_arready;
         rvalid <= next_rvalid;
         rdata <= next_rdata;
         rresp <= next_rresp;
      end
   end

   // ==========================================================
   // Checks
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   fixed_ones_a: assert property ((conditionFlags & CFP_FIXED_ONES) == CFP_FIXED_ONES) // RULE_11
      else $error("fixed flag bits not one");
   tap_write_a: assert property (take && cmd.op == OP_TAP |=> // RULE_23
      conditionFlags == ($past(accumulator) | CFP_FIXED_ONES))
      else $error("flag transfer wrong");
   sp_adjust_a: assert property (take && cmd.op == OP_STKADJ |=> // RULE_05
      stackPointer == $past(stackPointer) + $past(sext8))
      else $error("stack adjust wrong");
   sp_low_a: assert property (take && cmd.op == OP_STKLO |=> // RULE_07
      stackPointer[15:8] == $past(stackPointer[15:8])
      && stackPointer[7:0] == CFP_STK_LO_RESET)
      else $error("stack low reset wrong");
   pc_fetch_a: assert property (take && cmd.op == OP_FETCH |=> // RULE_08
      programCounter == $past(programCounter) + 16'h0001)
      else $error("counter did not advance");
   pc_jump_a: assert property (take && cmd.op == OP_JUMP |=> // RULE_09
      programCounter == $past(cmd.data))
      else $error("jump target not loaded");
   pc_vector_a: assert property (state == CFP_ST_VECLO |-> ##2 // RULE_10
      programCounter == {$past(memRdata, 2), $past(memRdata)} && state == CFP_ST_RUN)
      else $error("vector not loaded");
   mask_gate_a: assert property (irqTake |-> // RULE_15
      $past(conditionFlags[CFP_I_BIT]) == 1'b0)
      else $error("interrupt taken while masked");
   mask_hold_a: assert property (take && cmd.boundary // RULE_17
      && (inhibit || clearsMask) |=> !irqTake)
      else $error("interrupt right after mask clear");
   entry_mask_a: assert property (take && cmd.op == OP_INTENTRY |=> // RULE_16
      conditionFlags[CFP_I_BIT] && programCounter == $past(cmd.data))
      else $error("entry did not set mask");
   half_carry_a: assert property (take && cmd.op == OP_ADD |=> // RULE_13
      conditionFlags[CFP_H_BIT] == $past(nibSum[4]))
      else $error("half carry wrong");
   load16_a: assert property (take && cmd.op == OP_LDHX |=> // RULE_19
      index == $past(cmd.data) && conditionFlags[CFP_Z_BIT] == (index == 16'h0000))
      else $error("pair load wrong");

   boot_c: cover property (state == CFP_ST_VECDONE ##1 state == CFP_ST_RUN);
   irq_c: cover property (irqTake);
   decadj_c: cover property (take && cmd.op == OP_DADJ);
   branch_c: cover property (take && branchOk && cmd.op == OP_SLT);
endmodule // cfp_cpu_regs

// ---- hdl/cfp_pkg.sv ----
package cfp_pkg;
   // ==========================================================
   // Condition flag layout
   localparam int         CFP_V_BIT       = 7;
   localparam int         CFP_H_BIT       = 4;
   localparam int         CFP_I_BIT       = 3;
   localparam int         CFP_N_BIT       = 2;
   localparam int         CFP_Z_BIT       = 1;
   localparam int         CFP_C_BIT       = 0;
   localparam logic [7:0] CFP_FIXED_ONES  = 8'h60;
   localparam logic [7:0] CFP_FLAGS_RESET = 8'h68;

   // ==========================================================
   // Reset values and vector addresses
   localparam logic [7:0]  CFP_H_RESET      = 8'h00;
   localparam logic [15:0] CFP_STK_RESET    = 16'h00ff;
   localparam logic [7:0]  CFP_STK_LO_RESET = 8'hff;
   localparam logic [15:0] CFP_VEC_HI_ADDR  = 16'hfffe;
   localparam logic [15:0] CFP_VEC_LO_ADDR  = 16'hffff;

   // ==========================================================
   // Decimal adjust
   localparam logic [7:0] CFP_ADJ_LO        = 8'h06;
   localparam logic [7:0] CFP_ADJ_HI        = 8'h60;
   localparam logic [3:0] CFP_BCD_DIGIT_MAX = 4'h9;
   localparam logic [7:0] CFP_BCD_BYTE_MAX  = 8'h99;

   // ==========================================================
   // Bus map
   localparam logic [7:0] CFP_ADDR_INDEX  = 8'h00;
   localparam logic [7:0] CFP_ADDR_STACK  = 8'h04;
   localparam logic [7:0] CFP_ADDR_CNT    = 8'h08;
   localparam logic [7:0] CFP_ADDR_ACCFLG = 8'h0c;
   localparam logic [7:0] CFP_ADDR_CTRL   = 8'h10;
   localparam logic [1:0] CFP_RESP_OKAY   = 2'b00;
   localparam logic [1:0] CFP_RESP_SLVERR = 2'b10;
   localparam int         CFP_FREEZE_BIT  = 0;
   localparam int         CFP_RUN_BIT     = 1;
   localparam int         CFP_INHIBIT_BIT = 2;

   typedef enum logic [5:0] {
      OP_NOP, OP_FETCH, OP_JUMP, OP_INTENTRY, OP_BRA, OP_SGT, OP_SGE,
      OP_SLE, OP_SLT, OP_LDA, OP_LDX, OP_LDHX, OP_STORE8, OP_STORE16,
      OP_TAX, OP_TXA, OP_XCLR, OP_XINC, OP_XDEC, OP_XCOM, OP_XNEG,
      OP_XLSL, OP_XLSR, OP_XROL, OP_XROR, OP_ADD, OP_ADC, OP_SUB,
      OP_SBC, OP_DADJ, OP_STKADJ, OP_STKLO, OP_SPINC, OP_SPDEC, OP_LDSP,
      OP_TAP, OP_TPA, OP_MCLR, OP_SEI
   } cfp_op_type;

   typedef enum logic [3:0] {
      CFP_ST_VECHI   = 4'b0001,
      CFP_ST_VECLO   = 4'b0010,
      CFP_ST_VECDONE = 4'b0100,
      CFP_ST_RUN     = 4'b1000
   } cfp_state_type;

   typedef struct packed {
      logic       valid;
      logic       boundary;
      cfp_op_type op;
      logic [15:0] data;
   } cfp_cmd_type;
endpackage

// ---- hdl/cfp_alu.sv ----
`timescale 1ns/1ns
// ==========================================================
// Byte arithmetic and flag update
module cfp_alu (
   input  wire cfp_pkg::cfp_op_type op,
   input  wire logic [7:0]          opA,
   input  wire logic [7:0]          opB,
   input  wire logic [7:0]          flagsIn,
   output logic [7:0]               result,
   output logic [7:0]               flagsOut
);
   import cfp_pkg::*;

   logic [8:0] wide;
   logic [4:0] nib;
   logic [7:0] corr;
   logic       ci;
   logic       v;
   logic       h;
   logic       c;
   logic       upd;

   always_comb begin
      ci = flagsIn[CFP_C_BIT] && (op == OP_ADC || op == OP_SBC);
      wide = 9'h000;
      nib = 5'h00;
      corr = 8'h00;
      v = flagsIn[CFP_V_BIT];
      h = flagsIn[CFP_H_BIT];
      c = flagsIn[CFP_C_BIT];
      upd = 1'b1;
      result = opB;
      case (op)
         OP_ADD, OP_ADC: begin
            wide = {1'b0, opA} + {1'b0, opB} + {8'h00, ci};
            nib = {1'b0, opA[3:0]} + {1'b0, opB[3:0]} + {4'h0, ci};
            result = wide[7:0];
            h = nib[4]; // RULE_13
            c = wide[8]; // RULE_20
            v = (opA[7] == opB[7]) && (result[7] != opA[7]); // RULE_12
         end
         OP_SUB, OP_SBC: begin
            wide = {1'b0, opA} - {1'b0, opB} - {8'h00, ci};
            result = wide[7:0];
            c = wide[8]; // RULE_20
            v = (opA[7] != opB[7]) && (result[7] != opA[7]); // RULE_12
         end
         OP_LDA, OP_LDX, OP_STORE8: v = 1'b0;
         OP_XCLR: begin
            result = 8'h00;
            v = 1'b0;
            c = 1'b0;
         end
         OP_XINC: begin
            result = opA + 8'h01;
            v = (opA == 8'h7f);
         end
         OP_XDEC: begin
            result = opA - 8'h01;
            v = (opA == 8'h80);
         end
         OP_XCOM: begin
            result = ~opA;
            v = 1'b0;
            c = 1'b1;
         end
         OP_XNEG: begin
            result = 8'h00 - opA;
            v = (opA == 8'h80);
            c = (opA != 8'h00);
         end
         OP_XLSL, OP_XROL: begin
            result = {opA[6:0], op == OP_XROL && c};
            c = opA[7]; // RULE_20
            v = result[7] ^ opA[7];
         end
         OP_XLSR, OP_XROR: begin
            result = {op == OP_XROR && c, opA[7:1]};
            c = opA[0]; // RULE_20
            v = result[7] ^ opA[0];
         end
         OP_DADJ: begin
            // Correction from the flags left by the preceding add
            if (h || opA[3:0] > CFP_BCD_DIGIT_MAX) corr = CFP_ADJ_LO; // RULE_14
            if (c || opA > CFP_BCD_BYTE_MAX) begin
               corr = corr | CFP_ADJ_HI;
               c = 1'b1;
            end
            result = opA + corr;
         end
         default: upd = 1'b0;
      endcase
      flagsOut = flagsIn | CFP_FIXED_ONES;
      flagsOut[CFP_V_BIT] = v;
      flagsOut[CFP_H_BIT] = h;
      flagsOut[CFP_C_BIT] = c;
      if (upd) begin
         flagsOut[CFP_N_BIT] = result[7]; // RULE_18
         flagsOut[CFP_Z_BIT] = (result == 8'h00); // RULE_19
      end
   end
endmodule // cfp_alu

// ---- tb/cpu_pointer_and_flag_registers_bench.sv ----
`timescale 1ns/1ns
module cpu_pointer_and_flag_registers_bench import cfp_pkg::*; ;
   logic        mclk, rst_n, irqPending, cmdReady, memRead, irqTake;
   logic        awvalid, wvalid, bready, arvalid, rready, awready, wready;
   logic        bvalid, arready, rvalid;
   logic [1:0]  bresp, rresp, r;
   logic [3:0]  wstrb;
   logic [7:0]  memRdata, awaddr, araddr, conditionFlags, accumulator, a, b;
   logic [15:0] memAddr, index, stackPointer, programCounter, e, s;
   logic [31:0] wdata, rdata, rs, d, errorCnt, checked, cyc;
   cfp_cmd_type cmd;
   // Arbitrary reset vector
   localparam logic [15:0] VEC = 16'ha53c;

   cfp_cpu_regs i_dut (.mclk, .rst_n, .cmd, .irqPending, .memRdata, .cmdReady, .memRead,
      .memAddr, .index, .stackPointer, .programCounter, .conditionFlags, .accumulator,
      .irqTake, .awvalid, .awaddr, .wvalid, .wdata, .wstrb, .bready, .arvalid, .araddr,
      .rready, .awready, .wready, .bvalid, .bresp, .arready, .rvalid, .rdata, .rresp);

   // ==========================================================
   // Helpers
   function automatic logic [31:0] lf(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction
   function automatic logic [15:0] addx(input logic [7:0] x, y, input logic i);
      logic [8:0] t;
      t = x + y;
      return {t[7:0], x[7] == y[7] && t[7] != x[7], 2'b11, (x[3:0] + y[3:0]) > 5'h0f, i,
              t[7], t[7:0] == 8'h00, t[8]};
   endfunction
   task automatic conclude;
      $display("errors %0d checks %0d", errorCnt, checked);
      if (errorCnt == 0 && checked > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, exp);
      checked++;
      if (got !== exp) begin
         errorCnt++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic op(input cfp_op_type o, input logic [15:0] v, input logic bnd = 1'b1);
      @(posedge mclk);
      cmd <= '{1'b1, bnd, o, v};
      @(posedge mclk);
      cmd.valid <= 1'b0;
      #1;
   endtask
   task automatic axw(input logic [7:0] ad, input logic [31:0] wd, output logic [1:0] rp);
      logic ta, tw, tb;
      @(posedge mclk);
      awaddr <= ad; wdata <= wd; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
      tb = 1'b0;
      while (!tb) begin
         @(negedge mclk);
         ta = awvalid & awready; tw = wvalid & wready; tb = bvalid; rp = bresp;
         @(posedge mclk);
         if (ta) awvalid <= 1'b0;
         if (tw) wvalid <= 1'b0;
         if (tb) bready <= 1'b0;
      end
   endtask
   task automatic axr(input logic [7:0] ad, output logic [31:0] dv, output logic [1:0] rp);
      logic ta, tr;
      @(posedge mclk);
      araddr <= ad; arvalid <= 1'b1; rready <= 1'b1;
      tr = 1'b0;
      while (!tr) begin
         @(negedge mclk);
         ta = arvalid & arready; tr = rvalid; dv = rdata; rp = rresp;
         @(posedge mclk);
         if (ta) arvalid <= 1'b0;
         if (tr) rready <= 1'b0;
      end
   endtask

   // ==========================================================
   // Clock, vector memory and hang guard
   initial begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      memRdata <= (memAddr == CFP_VEC_HI_ADDR) ? VEC[15:8] : VEC[7:0];
      cyc <= cyc + 1;
      if (cyc == 32'h1388) begin
         errorCnt++;
         conclude();
      end
   end

   // ==========================================================
   // Scenarios
   initial begin
      rst_n = 1'b0; irqPending = 1'b0; cmd = '0; memRdata = 8'h00; cyc = 0;
      awvalid = 0; wvalid = 0; bready = 0; arvalid = 0; rready = 0; wstrb = 4'hf;
      awaddr = 8'h00; araddr = 8'h00; wdata = 0; rs = 32'hcafab030; errorCnt = 0; checked = 0;
      repeat (20) @(posedge mclk);
      rst_n <= 1'b1;
      repeat (4) @(posedge mclk);
      #1;
      chk(programCounter, VEC);
      chk(stackPointer, CFP_STK_RESET);
      chk(index[15:8], 8'h00);
      chk(conditionFlags & 8'h60, 8'h60);
      chk(memRead, 1'b0);
      chk(memAddr, CFP_VEC_LO_ADDR);
      chk(cmdReady, 1'b1);
      for (int k = 0; k < 8; k++) begin
         rs = lf(rs); a = rs[7:0]; b = rs[15:8];
         // Signed overflow and zero with carry as corners
         if (k == 0) begin a = 8'h7f; b = 8'h01; end
         if (k == 1) begin a = 8'h80; b = 8'h80; end
         op(OP_LDA, {8'h00, a});
         op(OP_ADD, {8'h00, b});
         e = addx(a, b, 1'b1);
         chk(accumulator, e[15:8]);
         chk(conditionFlags, e[7:0]);
      end
      op(OP_LDA, 16'h0009);
      // Load clears overflow and leaves a positive value: signed ge taken, lt not
      op(OP_SGE, 16'h0010);
      chk(programCounter, VEC + 16'h0010);
      op(OP_SLT, 16'h0010);
      chk(programCounter, VEC + 16'h0010);
      op(OP_ADD, 16'h0008);
      op(OP_DADJ, 16'h0000);
      chk(accumulator, 8'h17);
      a = rs[7:0] & 8'h97;
      op(OP_LDA, {8'h00, a});
      op(OP_TAP, 16'h0000);
      chk(conditionFlags, a | 8'h60);
      op(OP_TAX, 16'h0000);
      op(OP_XINC, 16'h0000);
      chk(index[7:0], a + 8'h01);
      rs = lf(rs);
      op(OP_LDHX, rs[31:16]);
      chk(index, rs[31:16]);
      op(OP_LDSP, rs[15:0]);
      op(OP_STKADJ, 16'h0080);
      s = rs[15:0] - 16'h0080;
      chk(stackPointer, s);
      op(OP_STKLO, 16'h0000);
      chk(stackPointer, {s[15:8], 8'hff});
      op(OP_JUMP, rs[31:16]);
      chk(programCounter, rs[31:16]);
      op(OP_FETCH, 16'h0000);
      chk(programCounter, 16'(rs[31:16] + 16'h0001));
      op(OP_BRA, 16'h00fe);
      chk(programCounter, 16'(rs[31:16] - 16'h0001));
      op(OP_SEI, 16'h0000);
      irqPending <= 1'b1;
      op(OP_FETCH, 16'h0000);
      chk(irqTake, 1'b0);
      op(OP_MCLR, 16'h0000, 1'b0);
      op(OP_FETCH, 16'h0000);
      chk(irqTake, 1'b0);
      op(OP_FETCH, 16'h0000);
      chk(irqTake, 1'b1);
      irqPending <= 1'b0;
      op(OP_INTENTRY, rs[15:0]);
      chk(conditionFlags[CFP_I_BIT], 1'b1);
      axw(CFP_ADDR_STACK, 32'h0000_0001, r);
      chk(r, CFP_RESP_SLVERR);
      chk(stackPointer, {s[15:8], 8'hff});
      axr(CFP_ADDR_CNT, d, r);
      chk(d[15:0], rs[15:0]);
      axr(8'h20, d, r);
      chk(r, CFP_RESP_SLVERR);
      // Freeze: status shows frozen and running, and a command is refused
      axw(CFP_ADDR_CTRL, 32'h0000_0001, r);
      chk(r, CFP_RESP_OKAY);
      axr(CFP_ADDR_CTRL, d, r);
      chk(d, 32'h0000_0003);
      chk(cmdReady, 1'b0);
      op(OP_FETCH, 16'h0000);
      chk(programCounter, rs[15:0]);
      conclude();
   end
endmodule // cpu_pointer_and_flag_registers_bench
